// ### pre_bit_if.sv
// bit stream carrier between sequencer and codeword shifter
`timescale 1ns/1ps
`default_nettype none

interface pre_bit_if;
  logic        bit_tick;
  logic        bit_val;
  logic [31:0] next_word;
  logic        pre_hit;
  logic        sync_hit;

  modport seq (output bit_tick, output bit_val, input next_word, input pre_hit, input sync_hit);
  modport shf (input bit_tick, input bit_val, output next_word, output pre_hit, output sync_hit);
endinterface : pre_bit_if

`default_nettype wire

// ### pre_cw_shift.sv
// codeword shift register with preamble and sync word detection
`timescale 1ns/1ps
`default_nettype none
`include "pre_defs.svh"

module pre_cw_shift
  import pre_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic clk_en_in,
  pre_bit_if.shf    bits
);

  logic [31:0] word_q;
  logic [15:0] alt_pat;

  // hits look at the word including the bit arriving now, so the
  // sequencer can act in the same cycle as the tick
  assign bits.next_word = {word_q[30:0], bits.bit_val};
  assign alt_pat        = {8{2'b10}};
  assign bits.pre_hit   = bits.bit_tick &&
                          ((bits.next_word[15:0] == alt_pat) ||
                           (bits.next_word[15:0] == ~alt_pat));
  // exact match only: no bit error correction of the sync word
  assign bits.sync_hit  = bits.bit_tick && (bits.next_word == `PRE_SYNC_WORD);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      word_q <= 32'h0000_0000;
    end else if (clk_en_in && bits.bit_tick) begin
      word_q <= bits.next_word;
    end
  end

endmodule : pre_cw_shift

`default_nettype wire

// ### pre_defs.svh
// constants of the pager receiver power economy sequencer
`ifndef PRE_DEFS_SVH
`define PRE_DEFS_SVH

`define PRE_SYNC_WORD     32'h7CD215D8
`define PRE_CW_BITS       32
`define PRE_BATCH_BITS    544
`define PRE_CW_FLAG_BIT   31
`define PRE_ADDR_MSB      30
`define PRE_ADDR_LSB      13
`define PRE_ADDR_W        18
`define PRE_FRAME_W       3
`define PRE_BAUD_512      512
`define PRE_BAUD_1200     1200
`define PRE_BAUD_2400     2400
`define PRE_WAKE_MS_512   1000
`define PRE_WAKE_MS_1200  500
`define PRE_WAKE_MS_2400  500
`define PRE_SAMPLE_BITS   64
`define PRE_LOSS_BITS     64
`define PRE_PRE_RUN       16
`define PRE_FAST_CHG_US   100
`define PRE_CHG_RST       1'b1

`endif

// ### pre_pkg.sv
// types of the pager receiver power economy sequencer
package pre_pkg;

  typedef enum logic [1:0] {
    PRE_BAUD_SEL_512,
    PRE_BAUD_SEL_1200,
    PRE_BAUD_SEL_2400,
    PRE_BAUD_SEL_RSVD
  } pre_baud_t;

  typedef enum logic [1:0] {
    PRE_ST_STANDBY,
    PRE_ST_SAMPLE,
    PRE_ST_PREAMBLE,
    PRE_ST_LOCKED
  } pre_state_t;

endpackage : pre_pkg

// ### pre_power_monitor.sv
// port checker of the receiver power economy sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pre_defs.svh"

module pre_power_monitor
  import pre_pkg::*;
#(
  parameter int CLK_HZ = 50_000_000
) (
  input wire logic                    clk_in,
  input wire logic                    reset_n_in,
  input wire logic                    clk_en_in,
  input wire logic                    rx_data_in,
  input wire logic [1:0]              baud_sel_in,
  input wire logic [`PRE_ADDR_W-1:0]  own_addr_in,
  input wire logic [`PRE_FRAME_W-1:0] own_frame_in,
  input wire logic                    rx_power_strobe_out,
  input wire logic                    slicer_charge_select_out,
  input wire logic                    host_attention_out,
  input wire logic                    batch_locked_out
);
  localparam int FAST = CLK_HZ / 10_000;
  localparam int CAP  = 2 * CLK_HZ;
  int on_cnt_q;
  int off_cnt_q;
  int rst_cnt_q;

  default clocking mon_cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  // all saturate so a long run cannot wrap into a false pass
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) on_cnt_q <= 0;
    else if (!rx_power_strobe_out) on_cnt_q <= 0;
    else if (on_cnt_q < CAP) on_cnt_q <= on_cnt_q + 1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) off_cnt_q <= 0;
    else if (rx_power_strobe_out) off_cnt_q <= 0;
    else if (off_cnt_q < CAP) off_cnt_q <= off_cnt_q + 1;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rst_cnt_q <= 0;
    else if (rst_cnt_q < CAP) rst_cnt_q <= rst_cnt_q + 1;
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_host_attention_pulse: assert property (host_attention_out && clk_en_in |=> !host_attention_out)
    else $error("attention longer than one cycle");
  a_host_attention_locked: assert property (
    host_attention_out |-> batch_locked_out || $past(batch_locked_out))
    else $error("attention outside batch lock");
  a_lock_powered: assert property ($rose(batch_locked_out) |-> $past(rx_power_strobe_out))
    else $error("lock gained with receiver off");
  a_lock_loss: assert property ($fell(batch_locked_out) |-> ##[0:2] !rx_power_strobe_out)
    else $error("receiver left on after lock loss");
  a_chg_switch_on: assert property (
    rx_power_strobe_out && on_cnt_q >= 1 && on_cnt_q <= FAST |-> slicer_charge_select_out)
    else $error("no fast charge at switch-on");
  a_chg_release: assert property (on_cnt_q > FAST + 1 |-> !slicer_charge_select_out)
    else $error("fast charge held too long");
  a_chg_reset: assert property (rst_cnt_q < FAST |-> slicer_charge_select_out)
    else $error("no fast charge after reset");
  a_wake_bound: assert property (off_cnt_q <= CLK_HZ)
    else $error("receiver off longer than one second");
  a_freeze_hold: assert property (!clk_en_in |=> $stable(rx_power_strobe_out) &&
    $stable(slicer_charge_select_out) && $stable(batch_locked_out))
    else $error("outputs moved while clock enable low");
endmodule : pre_power_monitor

bind pre_power_seq pre_power_monitor #(.CLK_HZ(CLK_HZ)) u_monitor (
  .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .rx_data_in(rx_data_in),
  .baud_sel_in(baud_sel_in), .own_addr_in(own_addr_in), .own_frame_in(own_frame_in),
  .rx_power_strobe_out(rx_power_strobe_out),
  .slicer_charge_select_out(slicer_charge_select_out),
  .host_attention_out(host_attention_out), .batch_locked_out(batch_locked_out)
);

`default_nettype wire

// ### pre_power_seq.sv
// battery economy power sequencer of a paging receiver decoder
//
// Summary of operation
// - In standby the receiver supply is switched on briefly once per wake interval to look for preamble.
// - While preamble is seen the receiver stays on and the decoder hunts for the sync word.
// - Finding the sync word enters batch lock aligned to the received batch structure.
// - In batch lock the receiver is on only for the sync word and the own frame, longer while a message runs.
// - At switch-on the slicer charge-select output is high for fast reference charging.
// - After the fast-charge interval the charge-select output goes low for normal slicing.
// - The serial bit stream is taken from the comparator data output through a two-flop synchroniser.
// - After preamble, a matching address and message, a host attention pulse is raised.
// - The standby wake interval is between half a second and one second by baud rate.
`timescale 1ns/1ps
`default_nettype none
`include "pre_defs.svh"

module pre_power_seq
  import pre_pkg::*;
#(
  parameter int CLK_HZ      = 50_000_000,
  parameter int SAMPLE_BITS = `PRE_SAMPLE_BITS,
  parameter int LOSS_BITS   = `PRE_LOSS_BITS
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  input  wire logic                    clk_en_in,
  input  wire logic                    rx_data_in,
  input  wire logic [1:0]              baud_sel_in,
  input  wire logic [`PRE_ADDR_W-1:0]  own_addr_in,
  input  wire logic [`PRE_FRAME_W-1:0] own_frame_in,
  output var  logic                    rx_power_strobe_out,
  output var  logic                    slicer_charge_select_out,
  output var  logic                    host_attention_out,
  output var  logic                    batch_locked_out
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (CLK_HZ < 4 * `PRE_BAUD_2400) begin : g_bad_clk
    $error("clock too slow for the highest baud rate");
  end
  if (SAMPLE_BITS < `PRE_PRE_RUN || SAMPLE_BITS > 1023) begin : g_bad_sample
    $error("sample window must hold a preamble run and fit 10 bits");
  end
  if (LOSS_BITS < `PRE_PRE_RUN || LOSS_BITS > 1023) begin : g_bad_loss
    $error("preamble loss window must hold a preamble run and fit 10 bits");
  end

  // scale in kilohertz: whole megahertz would round a slow clock down to no charge at all
  localparam int FAST_CHG_CYC = ((CLK_HZ / 1000) * `PRE_FAST_CHG_US) / 1000;
  localparam logic [23:0] FAST_CHG_INIT = 24'(FAST_CHG_CYC);

  if (FAST_CHG_CYC < 1 || FAST_CHG_CYC > 24'hFF_FFFF) begin : g_bad_chg
    $error("fast charge interval must be 1 to 2**24-1 cycles");
  end

  // ---------------------------------------------------------------
  // baud decoding
  // ---------------------------------------------------------------
  function automatic int baud_of(input logic [1:0] sel);
    unique case (pre_baud_t'(sel))
      PRE_BAUD_SEL_512:  baud_of = `PRE_BAUD_512;
      PRE_BAUD_SEL_2400: baud_of = `PRE_BAUD_2400;
      default:           baud_of = `PRE_BAUD_1200;
    endcase
  endfunction : baud_of

  function automatic int wake_ms_of(input logic [1:0] sel);
    unique case (pre_baud_t'(sel))
      PRE_BAUD_SEL_512:  wake_ms_of = `PRE_WAKE_MS_512;
      PRE_BAUD_SEL_2400: wake_ms_of = `PRE_WAKE_MS_2400;
      default:           wake_ms_of = `PRE_WAKE_MS_1200;
    endcase
  endfunction : wake_ms_of

  logic [23:0] bit_cyc;
  logic [10:0] wake_bits;

  assign bit_cyc   = 24'(CLK_HZ / baud_of(baud_sel_in));
  assign wake_bits = 11'((wake_ms_of(baud_sel_in) * baud_of(baud_sel_in)) / 1000);

  // ---------------------------------------------------------------
  // comparator data synchroniser and bit timebase
  // ---------------------------------------------------------------
  logic        rx_meta_q;
  logic        rx_sync_q;
  logic [23:0] tb_cnt_q;
  logic        tick;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
    end else if (clk_en_in) begin
      rx_meta_q <= rx_data_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  // free-running, no clock recovery: the transmitter rate must match the
  // local clock closely enough to stay within half a bit over a batch
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tb_cnt_q <= 24'h00_0000;
    end else if (clk_en_in) begin
      tb_cnt_q <= (tb_cnt_q >= bit_cyc - 24'h00_0001) ? 24'h00_0000 : tb_cnt_q + 24'h00_0001;
    end
  end

  assign tick = clk_en_in && (tb_cnt_q == (bit_cyc >> 1));

  // ---------------------------------------------------------------
  // codeword shifter
  // ---------------------------------------------------------------
  pre_bit_if bits ();

  assign bits.bit_tick = tick && rx_power_strobe_out;
  assign bits.bit_val  = rx_sync_q;

  pre_cw_shift u_shift (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .clk_en_in  (clk_en_in),
    .bits       (bits)
  );

  // ---------------------------------------------------------------
  // codeword decoding in lock
  // ---------------------------------------------------------------
  pre_state_t  state_q;
  logic [10:0] cnt_q;
  logic [9:0]  batch_bit_q;
  logic        msg_active_q;
  logic        msg_seen_q;
  logic [4:0]  cw_idx;
  logic        cw_end;
  logic        in_frame;
  logic        is_msg;
  logic        addr_hit;

  assign cw_idx   = batch_bit_q[9:5];
  assign cw_end   = bits.bit_tick && (batch_bit_q[4:0] == 5'h1F);
  assign in_frame = (cw_idx == {1'b0, own_frame_in, 1'b1}) ||
                    (cw_idx == 5'({own_frame_in, 1'b1}) + 5'h01);
  assign is_msg   = bits.next_word[`PRE_CW_FLAG_BIT];
  assign addr_hit = !is_msg && in_frame &&
                    (bits.next_word[`PRE_ADDR_MSB:`PRE_ADDR_LSB] == own_addr_in);

  // ---------------------------------------------------------------
  // economy state machine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= PRE_ST_STANDBY;
      cnt_q   <= 11'h000;
    end else if (clk_en_in) begin
      unique case (state_q)
        PRE_ST_STANDBY: begin
          if (tick) begin
            if (cnt_q >= wake_bits - 11'h001) begin
              state_q <= PRE_ST_SAMPLE;
              cnt_q   <= 11'h000;
            end else begin
              cnt_q <= cnt_q + 11'h001;
            end
          end
        end
        PRE_ST_SAMPLE: begin
          if (bits.pre_hit) begin
            state_q <= PRE_ST_PREAMBLE;
            cnt_q   <= 11'h000;
          end else if (bits.bit_tick) begin
            if (cnt_q >= 11'(SAMPLE_BITS - 1)) begin
              state_q <= PRE_ST_STANDBY;
              cnt_q   <= 11'h000;
            end else begin
              cnt_q <= cnt_q + 11'h001;
            end
          end
        end
        PRE_ST_PREAMBLE: begin
          if (bits.sync_hit) begin
            state_q <= PRE_ST_LOCKED;
            cnt_q   <= 11'h000;
          end else if (bits.pre_hit) begin
            cnt_q <= 11'h000;
          end else if (bits.bit_tick) begin
            if (cnt_q >= 11'(LOSS_BITS - 1)) begin
              state_q <= PRE_ST_STANDBY;
              cnt_q   <= 11'h000;
            end else begin
              cnt_q <= cnt_q + 11'h001;
            end
          end
        end
        PRE_ST_LOCKED: begin
          // a missed sync word drops lock
          if (cw_end && cw_idx == 5'h00 && !bits.sync_hit) begin
            state_q <= PRE_ST_STANDBY;
            cnt_q   <= 11'h000;
          end
        end
      endcase
    end
  end

  // batch position, aligned so the bit after the sync word is index 32
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      batch_bit_q <= 10'h000;
    end else if (clk_en_in && tick) begin
      if (state_q == PRE_ST_PREAMBLE && bits.sync_hit) begin
        batch_bit_q <= 10'(`PRE_CW_BITS);
      end else if (state_q == PRE_ST_LOCKED) begin
        batch_bit_q <= (batch_bit_q == 10'(`PRE_BATCH_BITS - 1)) ? 10'h000
                                                                : batch_bit_q + 10'h001;
      end
    end
  end

  // message tracking: address opens, a later non-message codeword closes
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      msg_active_q       <= 1'b0;
      msg_seen_q         <= 1'b0;
      host_attention_out <= 1'b0;
    end else if (clk_en_in) begin
      host_attention_out <= 1'b0;
      if (state_q != PRE_ST_LOCKED) begin
        msg_active_q <= 1'b0;
        msg_seen_q   <= 1'b0;
      end else if (cw_end && cw_idx != 5'h00) begin
        if (msg_active_q && is_msg) begin
          msg_seen_q <= 1'b1;
        end else if (msg_active_q) begin
          host_attention_out <= msg_seen_q;
          msg_active_q       <= addr_hit;
          msg_seen_q         <= 1'b0;
        end else if (addr_hit) begin
          msg_active_q <= 1'b1;
          msg_seen_q   <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // receiver supply and slicer charge control
  // ---------------------------------------------------------------
  logic        rx_on_d;
  logic        lock_win;
  logic [23:0] chg_cnt_q;

  assign lock_win = (cw_idx == 5'h00) || in_frame || msg_active_q;

  always_comb begin
    unique case (state_q)
      PRE_ST_STANDBY: rx_on_d = 1'b0;
      PRE_ST_LOCKED:  rx_on_d = lock_win;
      default:        rx_on_d = 1'b1;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_power_strobe_out <= 1'b0;
      batch_locked_out    <= 1'b0;
    end else if (clk_en_in) begin
      rx_power_strobe_out <= rx_on_d;
      batch_locked_out    <= (state_q == PRE_ST_LOCKED);
    end
  end

  // fast charge at power-up and again at every receiver switch-on, since
  // the reference capacitor drifts while the receiver sleeps
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chg_cnt_q                <= FAST_CHG_INIT;
      slicer_charge_select_out <= `PRE_CHG_RST;
    end else if (clk_en_in) begin
      if (rx_on_d && !rx_power_strobe_out) begin
        chg_cnt_q                <= FAST_CHG_INIT;
        slicer_charge_select_out <= 1'b1;
      end else if (chg_cnt_q != 24'h00_0000) begin
        chg_cnt_q                <= chg_cnt_q - 24'h00_0001;
        slicer_charge_select_out <= 1'b1;
      end else begin
        slicer_charge_select_out <= 1'b0;
      end
    end
  end

endmodule : pre_power_seq

`default_nettype wire

// ### pre_rx_model.sv
// behavioural radio front end and data comparator feeding the sequencer
`timescale 1ns/1ps
`default_nettype none

module pre_rx_model #(
  parameter int P = 20
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic rx_power_strobe_in,
  output var  logic rx_data_out
);
  logic q[$];
  logic cur;
  int   cnt;
  int   ph;

  initial begin
    rx_data_out = 1'b0;
    cur = 1'b0;
    cnt = 0;
    ph = 0;
  end

  // air bits go out msb first, one per bit period, whether or not anyone listens
  task automatic push_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) q.push_back(w[i]);
  endtask : push_word

  always @(negedge clk_in) begin
    if (!reset_n_in) begin
      cnt = 0;
    end else begin
      if (cnt == 0 && q.size() > 0) cur = q.pop_front();
      else if (cnt == 0) begin
        cur = (ph != 2);
        ph = (ph + 1) % 3;
      end
      cnt = (cnt == P - 1) ? 0 : cnt + 1;
    end
    // an unpowered comparator output means nothing: toggle it every clock
    rx_data_out = rx_power_strobe_in ? cur : ~rx_data_out;
  end
endmodule : pre_rx_model

`default_nettype wire

// ### pre_tb.sv
// self-checking testbench of the receiver power economy sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pre_defs.svh"

module testbench
  import pre_pkg::*;
;
  localparam int CLK_HZ = 50_000;
  localparam int P      = CLK_HZ / `PRE_BAUD_2400;
  localparam int W      = `PRE_WAKE_MS_2400 * `PRE_BAUD_2400 / 1000;
  localparam int SMP    = 32;
  localparam int FAST   = CLK_HZ / 10_000;
  localparam int LIMIT  = 90_000;

  logic                    clk_in;
  logic                    reset_n_in;
  logic                    clk_en_in;
  logic                    rx_data_in;
  logic [1:0]              baud_sel_in;
  logic [`PRE_ADDR_W-1:0]  own_addr_in;
  logic [`PRE_FRAME_W-1:0] own_frame_in;
  logic                    rx_power_strobe_out;
  logic                    slicer_charge_select_out;
  logic                    host_attention_out;
  logic                    batch_locked_out;
  int                      err_total;
  int                      comparisons;
  int                      cyc;
  int                      host_attention_seen;

  pre_power_seq #(.CLK_HZ(CLK_HZ), .SAMPLE_BITS(SMP)) uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .rx_data_in(rx_data_in),
    .baud_sel_in(baud_sel_in), .own_addr_in(own_addr_in), .own_frame_in(own_frame_in),
    .rx_power_strobe_out(rx_power_strobe_out),
    .slicer_charge_select_out(slicer_charge_select_out),
    .host_attention_out(host_attention_out), .batch_locked_out(batch_locked_out));

  pre_rx_model #(.P(P)) rx_model (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .rx_power_strobe_in(rx_power_strobe_out), .rx_data_out(rx_data_in));

  always #10 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask : check_bit

  task automatic check_int(input int got, input int exp, input string what);
    comparisons++;
    if (got != exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask : check_int

  // attention is a one-cycle pulse, so every falling edge is looked at
  task automatic step(input int n);
    repeat (n) begin
      @(negedge clk_in);
      if (host_attention_out === 1'b1) host_attention_seen++;
    end
  endtask : step

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    int n;
    n = 0;
    step(10);
    check_bit(slicer_charge_select_out, 1'b1, "charge in reset");
    reset_n_in = 1'b1;
    step(1);
    check_bit(rx_power_strobe_out, 1'b0, "strobe after reset");
    check_bit(batch_locked_out, 1'b0, "lock after reset");
    // a frozen clock enable must hold the charge pulse well past its length
    clk_en_in = 1'b0;
    step(20);
    check_bit(slicer_charge_select_out, 1'b1, "charge held while frozen");
    clk_en_in = 1'b1;
    while (slicer_charge_select_out === 1'b1 && n < 100) begin
      n++;
      step(1);
    end
    check_bit(n >= FAST && n <= FAST + 1, 1'b1, "charge after reset");
  endtask : t_reset

  task automatic t_wake();
    int n;
    n = 0;
    while (rx_power_strobe_out !== 1'b1 && n < 30_000) begin
      n++;
      step(1);
    end
    check_bit(rx_power_strobe_out, 1'b1, "first wake");
    n = 0;
    while (rx_power_strobe_out === 1'b1 && n < 5_000) begin
      n++;
      step(1);
    end
    check_bit(n >= (SMP - 1) * P && n <= (SMP + 1) * P, 1'b1, "sample length");
    while (rx_power_strobe_out !== 1'b1 && n < 30_000) begin
      n++;
      step(1);
    end
    check_bit(n >= (W - 1) * P && n <= (W + SMP + 1) * P, 1'b1, "wake period");
    repeat (3) rx_model.push_word(32'hAAAAAAAA);
    rx_model.push_word(`PRE_SYNC_WORD);
    rx_model.push_word({1'b0, own_addr_in, 13'h0000});
    rx_model.push_word(32'hC0FFEE00);
    repeat (15) rx_model.push_word(32'h00000000);
    n = 0;
    while (slicer_charge_select_out === 1'b1 && n < 100) begin
      n++;
      step(1);
    end
    check_int(n, FAST + 1, "charge at switch-on");
  endtask : t_wake

  task automatic t_lock();
    int n;
    int low;
    n = 0;
    low = 0;
    while (batch_locked_out !== 1'b1 && n < 6 * 32 * P) begin
      if (rx_power_strobe_out !== 1'b1) low++;
      n++;
      step(1);
    end
    check_bit(batch_locked_out, 1'b1, "lock on sync");
    check_int(low, 0, "receiver off in preamble");
  endtask : t_lock

  task automatic t_frame();
    host_attention_seen = 0;
    step(16 * P);
    check_bit(rx_power_strobe_out, 1'b1, "power in own frame");
    step(7 * 32 * P);
    check_bit(rx_power_strobe_out, 1'b0, "power outside frame");
    check_int(host_attention_seen, 1, "attention pulses");
    step(9 * 32 * P);
    check_bit(rx_power_strobe_out, 1'b1, "power in sync slot");
    check_bit(batch_locked_out, 1'b1, "lock held");
    step(17 * P);
    check_bit(batch_locked_out, 1'b0, "lock lost");
    check_bit(rx_power_strobe_out, 1'b0, "back to standby");
  endtask : t_frame

  initial begin
    clk_in = 1'b0;
    reset_n_in = 1'b0;
    clk_en_in = 1'b1;
    baud_sel_in = PRE_BAUD_SEL_2400;
    own_addr_in = 18'h1A2B3;
    own_frame_in = 3'h0;
    err_total = 0;
    comparisons = 0;
    cyc = 0;
    host_attention_seen = 0;
    t_reset();
    t_wake();
    t_lock();
    t_frame();
    final_report();
  end
endmodule : testbench

`default_nettype wire
